// ===== bench/core_model.sv
// Purpose: processor core stand-in issuing instruction fetches and data accesses
// Assumes: one access per call, launched right after a rising edge
// Notes: address lines carry a changing pattern between accesses so stale values never match
`timescale 1ns/1ps
module core_model (
	// clock
	input wire logic clk,
	// access request
	output logic acc_valid,
	output logic [31:0] acc_addr,
	output logic acc_write,
	output logic acc_fetch
);
	initial begin
		acc_valid = 1'b0;
		acc_addr = 32'h0;
		acc_write = 1'b0;
		acc_fetch = 1'b0;
	end
	task automatic issue(input logic [31:0] a, input logic w, input logic f);
		@(posedge clk);
		acc_valid <= 1'b1;
		acc_addr <= a;
		acc_write <= w;
		acc_fetch <= f;
		@(posedge clk);
		acc_valid <= 1'b0;
		acc_addr <= ~a;
		acc_write <= ~w;
	endtask : issue
endmodule : core_model

// ===== bench/testbench.sv
// Purpose: self-checking bench for the region protection unit
// Assumes: one-cycle access answer, one-cycle register ack
// Notes: reference model keeps region words, status, mask and fault address
`timescale 1ns/1ps
module testbench;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h0;
	logic [3:0] sel = 4'hf;
	logic [31:0] dat_w = 32'h0;
	logic [31:0] wb_dat_o, bus_addr;
	logic wb_ack_o, acc_valid, acc_write, acc_fetch, bus_valid, bus_write, bus_fetch, fault_valid, fault_fetch, irq;
	logic [31:0] acc_addr;
	logic [3:0] bus_attr, acc_region;
	logic [31:0] base_m[8], attr_m[8];
	logic [31:0] ctrl_m = rpu_pkg::CTRL_RST;
	logic [31:0] faddr_m = 32'h0;
	logic [1:0] stat_m = 2'h0;
	logic [1:0] mask_m = 2'h0;
	int err_count = 0;
	int check_count = 0;
	always #4 clk = ~clk;
	core_model core_u (.clk(clk), .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_write(acc_write),
		.acc_fetch(acc_fetch));
	region_protection_unit dut_u (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.acc_valid(acc_valid), .acc_addr(acc_addr), .acc_write(acc_write), .acc_fetch(acc_fetch),
		.bus_valid(bus_valid), .bus_addr(bus_addr), .bus_write(bus_write), .bus_fetch(bus_fetch),
		.bus_attr(bus_attr), .acc_region(acc_region), .fault_valid(fault_valid), .fault_fetch(fault_fetch),
		.irq(irq));
	task automatic conclude();
		if (err_count == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : conclude
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= ad;
		dat_w <= d;
		for (n = 0; n < 20 && wb_ack_o !== 1'b1; n++) @(posedge clk);
		q = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (n == 20) begin
			check(32'h0, 32'h1);
			conclude();
		end
	endtask : wb
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, ad, d, q);
		if (ad == rpu_pkg::CTRL_OFS) ctrl_m = d;
		if (ad == rpu_pkg::MASK_OFS && sel[0]) mask_m = d[1:0];
		if (ad >= 8'h10 && ad < 8'h50 && ad[2]) attr_m[(ad - 8'h10) >> 3] = d;
		if (ad >= 8'h10 && ad < 8'h50 && !ad[2]) base_m[(ad - 8'h10) >> 3] = d;
	endtask : wr
	task automatic rd(input logic [7:0] ad, input logic [31:0] exp);
		logic [31:0] q;
		wb(1'b0, ad, 32'h0, q);
		check(q, exp);
	endtask : rd
	task automatic access(input logic [31:0] a, input logic w, input logic f);
		logic [3:0] r;
		logic [3:0] at;
		logic [1:0] ap;
		logic pf, gf, xn;
		int s;
		r = rpu_pkg::DEF_REGION;
		ap = ctrl_m[2:1];
		xn = ctrl_m[3];
		at = ctrl_m[7:4];
		for (int n = 0; n < 8; n++) begin
			s = int'(attr_m[n][5:1]);
			if (ctrl_m[0] && attr_m[n][0] && s >= 4 && ((a ^ base_m[n]) >> (s + 1)) == 0 &&
				!(s >= 7 && attr_m[n][8 + ((a >> (s - 2)) & 7)])) begin
				r = 4'(n);
				ap = attr_m[n][17:16];
				xn = attr_m[n][18];
				at = attr_m[n][23:20];
			end
		end
		pf = !(ap == rpu_pkg::AP_RW || (ap == rpu_pkg::AP_RO && !w && 1'b1));
		gf = f && xn;
		core_u.issue(a, w, f);
		#1;
		stat_m = stat_m | {gf, pf};
		if (pf || gf) faddr_m = a;
		check(fault_valid, pf | gf);
		check(bus_valid, !(pf | gf));
		check(fault_fetch, gf);
		check(acc_region, r);
		check(irq, |(stat_m & mask_m));
		if (!(pf || gf)) check(bus_addr, a);
		if (!(pf || gf)) check({bus_write, bus_fetch, bus_attr}, {w, f, at});
	endtask : access
	initial begin
		void'($urandom(32'hfcb3e28d));
		foreach (base_m[n]) base_m[n] = 32'h0;
		foreach (attr_m[n]) attr_m[n] = 32'h0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		rd(rpu_pkg::CTRL_OFS, rpu_pkg::CTRL_RST);
		rd(8'h80, 32'h0);
		access(32'h2000_0040, 1'b1, 1'b0);
		wr(8'h20, 32'h2000_0000);
		wr(8'h24, 32'h0053_0017);
		wr(8'h38, 32'h2000_0000);
		wr(8'h3c, 32'h0095_0813);
		wr(8'h48, 32'h2000_0100);
		wr(8'h4c, 32'h00c0_0009);
		wr(8'h10, 32'h2000_1000);
		wr(8'h14, 32'h0033_810f);
		// region 1 is below the granule and must never match, though it outranks region 0
		wr(8'h18, 32'h2000_1040);
		wr(8'h1c, 32'h0000_0007);
		wr(rpu_pkg::CTRL_OFS, 32'h0000_00a9);
		sel <= 4'he;
		wr(rpu_pkg::MASK_OFS, 32'h3);
		sel <= 4'hf;
		rd(rpu_pkg::MASK_OFS, 32'h0);
		wr(rpu_pkg::MASK_OFS, 32'h3);
		access(32'h2000_1044, 1'b0, 1'b0);
		// random sweep over nested regions, sub-region holes and the background
		repeat (80) begin
			logic f;
			f = 1'($urandom);
			access(32'h2000_0000 + ($urandom % 32'h1400), f ? 1'b0 : 1'($urandom), f);
		end
		rd(rpu_pkg::FADDR_OFS, faddr_m);
		rd(rpu_pkg::STAT_OFS, {30'h0, stat_m});
		stat_m = 2'h0;
		access(32'h2000_0c00, 1'b0, 1'b0);
		wr(8'h3c, 32'h0093_0813);
		rd(8'h24, 32'h0053_0017);
		access(32'h2000_0000, 1'b0, 1'b1);
		conclude();
	end
	initial begin
		repeat (20000) @(posedge clk);
		check(32'h0, 32'h1);
		conclude();
	end
endmodule : testbench

// ===== src/region_match.sv
// Purpose: address match of one protection region with sub-region gating
// Assumes: base bits below the region size are ignored
// Notes: purely combinational
`timescale 1ns/1ps
module region_match (
	// access address
	input wire logic [31:0] addr,
	// region setup
	input wire logic [31:0] base,
	input wire logic en,
	input wire logic [4:0] size,
	input wire logic [7:0] srd,
	// result
	output logic hit
);
	logic [32:0] span;
	logic [31:0] low_mask;
	logic [4:0] sub_shamt;
	logic [2:0] sub_idx;
	logic sub_off;

	always_comb begin
		// six-bit shift amount so the 4 GB size code does not wrap to zero
		span = 33'h1 << ({1'b0, size} + 6'h1);
		low_mask = 32'(span - 33'h1);
		sub_shamt = size - rpu_pkg::SUB_SHIFT;
		sub_idx = 3'(addr >> sub_shamt);
		// sub-regions exist only from 256 bytes up
		sub_off = (size >= rpu_pkg::SIZE_SUB) && srd[sub_idx];
		hit = en && (size >= rpu_pkg::SIZE_MIN) && (((addr ^ base) & ~low_mask) == 32'h0) && !sub_off;
	end
endmodule : region_match

// ===== src/region_pick.sv
// Purpose: fixed-priority choice among matching regions
// Assumes: hit vector indexed by region number
// Notes: highest index wins; order is not programmable
`timescale 1ns/1ps
module region_pick #(
	parameter int N = 8
) (
	// matches
	input wire logic [N-1:0] hits,
	// winner
	output logic found,
	output logic [3:0] idx
);
	always_comb begin
		found = 1'b0;
		idx = rpu_pkg::DEF_REGION;
		// later loop passes override, so the top index wins
		for (int i = 0; i < N; i++) begin
			if (hits[i]) begin
				found = 1'b1;
				idx = 4'(i);
			end
		end
	end
endmodule : region_pick

// ===== src/region_protection_unit.sv
// Purpose: checks core accesses against eight regions and a background region
// Assumes: classic wishbone register slave, one access per cycle from the core
// Notes: one cycle from access to bus or fault output
`timescale 1ns/1ps
module region_protection_unit #(
	parameter int NREG = rpu_pkg::NREG
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// wishbone register slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// core access
	input wire logic acc_valid,
	input wire logic [31:0] acc_addr,
	input wire logic acc_write,
	input wire logic acc_fetch,
	// system bus side
	output logic bus_valid,
	output logic [31:0] bus_addr,
	output logic bus_write,
	output logic bus_fetch,
	output logic [rpu_pkg::MEM_W-1:0] bus_attr,
	output logic [3:0] acc_region,
	// fault to core
	output logic fault_valid,
	output logic fault_fetch,
	// interrupt
	output logic irq
);
	logic [31:0] ctrl_ff, nxt_ctrl;
	logic [31:0] base_ff [NREG], nxt_base [NREG];
	logic [31:0] attr_ff [NREG], nxt_attr [NREG];
	logic [rpu_pkg::ST_W-1:0] stat_ff, nxt_stat, mask_ff, nxt_mask;
	logic [31:0] faddr_ff, nxt_faddr;
	logic ack_ff, nxt_ack;
	logic [31:0] rdat_ff, nxt_rdat;
	logic irq_ff, nxt_irq;
	logic bv_ff, nxt_bv, bw_ff, nxt_bw, bf_ff, nxt_bf, fv_ff, nxt_fv, ff_ff, nxt_ff;
	logic [31:0] ba_ff, nxt_ba;
	logic [rpu_pkg::MEM_W-1:0] bm_ff, nxt_bm;
	logic [3:0] rg_ff, nxt_rg;

	logic [NREG-1:0] hits;
	logic found;
	logic [3:0] win;
	logic [1:0] win_ap;
	logic win_xn;
	logic [rpu_pkg::MEM_W-1:0] win_mem;
	logic perm_bad, fetch_bad;
	logic wb_req, wb_wr, wb_rd;
	logic [31:0] bmask, rsel;
	logic [7:0] roff;
	logic [2:0] ridx;

	// one matcher per region
	genvar g;
	generate
		for (g = 0; g < NREG; g++) begin : g_reg
			region_match u_match (
				.addr(acc_addr),
				.base(base_ff[g]),
				.en(attr_ff[g][rpu_pkg::AT_EN_BIT] && ctrl_ff[rpu_pkg::CTRL_EN_BIT]),
				.size(attr_ff[g][rpu_pkg::AT_SIZE_LSB +: 5]),
				.srd(attr_ff[g][rpu_pkg::AT_SRD_LSB +: rpu_pkg::NSUB]),
				.hit(hits[g])
			);
		end
	endgenerate

	region_pick #(.N(NREG)) u_pick (
		.hits(hits),
		.found(found),
		.idx(win)
	);

	// winning settings; background region when nothing matches
	always_comb begin
		ridx = win[2:0];
		if (found) begin
			win_ap = attr_ff[ridx][rpu_pkg::AT_AP_LSB +: 2];
			win_xn = attr_ff[ridx][rpu_pkg::AT_XN_BIT];
			win_mem = attr_ff[ridx][rpu_pkg::AT_MEM_LSB +: rpu_pkg::MEM_W];
		end else begin
			win_ap = ctrl_ff[rpu_pkg::CTRL_DAP_LSB +: 2];
			win_xn = ctrl_ff[rpu_pkg::CTRL_DXN_BIT];
			win_mem = ctrl_ff[rpu_pkg::CTRL_DMEM_LSB +: rpu_pkg::MEM_W];
		end
		// code 2 is treated as no access so a stray value fails safe
		perm_bad = !((win_ap == rpu_pkg::AP_RW) || (win_ap == rpu_pkg::AP_RO && !acc_write));
		fetch_bad = acc_fetch && win_xn;
	end

	// access path: pass or fault, never both
	always_comb begin
		nxt_bv = acc_valid && !perm_bad && !fetch_bad;
		nxt_fv = acc_valid && (perm_bad || fetch_bad);
		nxt_ff = acc_valid && fetch_bad;
		nxt_ba = acc_valid ? acc_addr : ba_ff;
		nxt_bw = acc_valid ? acc_write : bw_ff;
		nxt_bf = acc_valid ? acc_fetch : bf_ff;
		nxt_bm = acc_valid ? win_mem : bm_ff;
		nxt_rg = acc_valid ? win : rg_ff;
	end

	// register slave; ack one cycle after request, dropped the next cycle
	always_comb begin
		wb_req = wb_cyc_i && wb_stb_i && !ack_ff;
		wb_wr = wb_req && wb_we_i;
		wb_rd = wb_req && !wb_we_i;
		for (int b = 0; b < 4; b++) begin
			bmask[b*8 +: 8] = {8{wb_sel_i[b]}};
		end
		roff = wb_adr_i - rpu_pkg::RTAB_OFS;
		nxt_ack = wb_req;
		nxt_ctrl = ctrl_ff;
		nxt_mask = mask_ff;
		for (int i = 0; i < NREG; i++) begin
			nxt_base[i] = base_ff[i];
			nxt_attr[i] = attr_ff[i];
		end
		rsel = 32'h0;
		if (wb_adr_i == rpu_pkg::CTRL_OFS) begin
			rsel = ctrl_ff;
			if (wb_wr) nxt_ctrl = (ctrl_ff & ~bmask) | (wb_dat_i & bmask);
		end else if (wb_adr_i == rpu_pkg::STAT_OFS) begin
			rsel = 32'(stat_ff);
		end else if (wb_adr_i == rpu_pkg::MASK_OFS) begin
			rsel = 32'(mask_ff);
			if (wb_wr && wb_sel_i[0]) nxt_mask = wb_dat_i[rpu_pkg::ST_W-1:0];
		end else if (wb_adr_i == rpu_pkg::FADDR_OFS) begin
			rsel = faddr_ff;
		end else if (wb_adr_i >= rpu_pkg::RTAB_OFS && (roff >> rpu_pkg::RSTRIDE_LOG2) < 8'(NREG)) begin
			// only the addressed region's word changes
			if (roff[2:0] == rpu_pkg::RATTR_OFS[2:0]) begin
				rsel = attr_ff[roff[5:3]];
				if (wb_wr) nxt_attr[roff[5:3]] = (attr_ff[roff[5:3]] & ~bmask) | (wb_dat_i & bmask);
			end else if (roff[2:0] == 3'h0) begin
				rsel = base_ff[roff[5:3]];
				if (wb_wr) nxt_base[roff[5:3]] = (base_ff[roff[5:3]] & ~bmask) | (wb_dat_i & bmask);
			end
		end
		// unmapped addresses answer with zero and ignore writes
		nxt_rdat = wb_rd ? rsel : 32'h0;
	end

	// sticky events; a new event wins over the clear-on-read
	always_comb begin
		nxt_stat = stat_ff;
		if (wb_rd && wb_adr_i == rpu_pkg::STAT_OFS) nxt_stat = '0;
		if (nxt_fv && perm_bad) nxt_stat[rpu_pkg::ST_PERM_BIT] = 1'b1;
		if (nxt_ff) nxt_stat[rpu_pkg::ST_FETCH_BIT] = 1'b1;
		nxt_faddr = nxt_fv ? acc_addr : faddr_ff;
		nxt_irq = |(nxt_stat & nxt_mask);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_ff <= rpu_pkg::CTRL_RST;
			for (int i = 0; i < NREG; i++) begin
				base_ff[i] <= 32'h0;
				attr_ff[i] <= 32'h0;
			end
			stat_ff <= '0;
			mask_ff <= '0;
			faddr_ff <= 32'h0;
			ack_ff <= 1'b0;
			rdat_ff <= 32'h0;
			irq_ff <= 1'b0;
			bv_ff <= 1'b0;
			bw_ff <= 1'b0;
			bf_ff <= 1'b0;
			fv_ff <= 1'b0;
			ff_ff <= 1'b0;
			ba_ff <= 32'h0;
			bm_ff <= '0;
			rg_ff <= rpu_pkg::DEF_REGION;
		end else begin
			ctrl_ff <= nxt_ctrl;
			for (int i = 0; i < NREG; i++) begin
				base_ff[i] <= nxt_base[i];
				attr_ff[i] <= nxt_attr[i];
			end
			stat_ff <= nxt_stat;
			mask_ff <= nxt_mask;
			faddr_ff <= nxt_faddr;
			ack_ff <= nxt_ack;
			rdat_ff <= nxt_rdat;
			irq_ff <= nxt_irq;
			bv_ff <= nxt_bv;
			bw_ff <= nxt_bw;
			bf_ff <= nxt_bf;
			fv_ff <= nxt_fv;
			ff_ff <= nxt_ff;
			ba_ff <= nxt_ba;
			bm_ff <= nxt_bm;
			rg_ff <= nxt_rg;
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdat_ff;
	assign bus_valid = bv_ff;
	assign bus_addr = ba_ff;
	assign bus_write = bw_ff;
	assign bus_fetch = bf_ff;
	assign bus_attr = bm_ff;
	assign acc_region = rg_ff;
	assign fault_valid = fv_ff;
	assign fault_fetch = ff_ff;
	assign irq = irq_ff;

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	bg_region_a: assert property (acc_valid && hits == '0 |=> rg_ff == rpu_pkg::DEF_REGION)
		else $error("background region not used");
	region_wins_a: assert property (acc_valid && |hits |=> rg_ff != rpu_pkg::DEF_REGION)
		else $error("matching region lost to background");
	top_index_a: assert property (acc_valid && hits[NREG-1] |=> rg_ff == 4'(NREG-1))
		else $error("highest region did not win");
	sub_disable_a: assert property (ctrl_ff[rpu_pkg::CTRL_EN_BIT]
		&& attr_ff[0][rpu_pkg::AT_SIZE_LSB +: 5] == rpu_pkg::SIZE_SUB
		&& attr_ff[0][rpu_pkg::AT_SRD_LSB + acc_addr[7:5]] |-> !hits[0])
		else $error("disabled sub-region matched");
	small_size_a: assert property (attr_ff[1][rpu_pkg::AT_SIZE_LSB +: 5] < rpu_pkg::SIZE_MIN |-> !hits[1])
		else $error("region below granule matched");
	no_access_a: assert property (acc_valid && win_ap == rpu_pkg::AP_NONE |=> fault_valid && !bus_valid)
		else $error("no-access region let access through");
	read_only_a: assert property (acc_valid && win_ap == rpu_pkg::AP_RO && acc_write |=> fault_valid)
		else $error("write to read-only region passed");
	fetch_guard_a: assert property (acc_valid && acc_fetch && win_xn |=> fault_valid && fault_fetch)
		else $error("guarded fetch passed");
	other_region_a: assert property (wb_wr && wb_adr_i == rpu_pkg::RTAB_OFS + rpu_pkg::RATTR_OFS
		|=> $stable(attr_ff[1]) && $stable(base_ff[1]))
		else $error("write leaked into another region");
	attr_out_a: assert property (acc_valid && !perm_bad && !fetch_bad |=> bus_valid && bus_attr == $past(win_mem))
		else $error("attributes not exported");
	fault_block_a: assert property (fault_valid |-> !bus_valid)
		else $error("faulted access reached bus");
	irq_level_a: assert property (|(stat_ff & mask_ff) |-> irq) else $error("interrupt missing");
	// register slave handshake
	ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("register request not answered");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("acknowledge held past one cycle");
	rdat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data shown outside acknowledge");
	mask_write_a: assert property (wb_wr && wb_adr_i == rpu_pkg::MASK_OFS && wb_sel_i[0]
		|=> mask_ff == $past(wb_dat_i[rpu_pkg::ST_W-1:0]))
		else $error("mask write lost");
	// access path timing and results
	one_result_a: assert property (acc_valid |=> bus_valid != fault_valid)
		else $error("access gave no single result");
	idle_quiet_a: assert property (!acc_valid |=> !bus_valid && !fault_valid)
		else $error("result without access");
	region_out_a: assert property (acc_valid |=> acc_region == $past(win))
		else $error("winning region not reported");
	addr_out_a: assert property (acc_valid |=> bus_addr == $past(acc_addr)
		&& bus_write == $past(acc_write) && bus_fetch == $past(acc_fetch))
		else $error("access fields not passed on");
	guard_read_a: assert property (acc_valid && !acc_fetch && !perm_bad |=> bus_valid)
		else $error("guard refused a data access");
	// sticky status and fault address
	perm_event_a: assert property (acc_valid && perm_bad |=> stat_ff[rpu_pkg::ST_PERM_BIT]
		&& faddr_ff == $past(acc_addr))
		else $error("permission fault not recorded");
	fetch_event_a: assert property (acc_valid && fetch_bad |=> stat_ff[rpu_pkg::ST_FETCH_BIT])
		else $error("fetch fault not recorded");
	stat_sticky_a: assert property (|stat_ff && !(wb_rd && wb_adr_i == rpu_pkg::STAT_OFS) |=> |stat_ff)
		else $error("status bit lost without read");
	stat_clear_a: assert property (wb_rd && wb_adr_i == rpu_pkg::STAT_OFS && !acc_valid |=> stat_ff == '0)
		else $error("status read did not clear");

	pass_cov: cover property (bus_valid && acc_region != rpu_pkg::DEF_REGION);
	fault_cov: cover property (fault_valid && fault_fetch);
	overlap_cov: cover property (acc_valid && hits[0] && hits[NREG-1]);
	irq_cov: cover property (irq ##1 wb_ack_o);
	ro_fault_cov: cover property (fault_valid && !fault_fetch);
endmodule : region_protection_unit

// ===== src/rpu_pkg.sv
// Purpose: constants shared by the region protection unit files
// Assumes: 32-bit addresses, classic wishbone register bus
// Notes: region attribute word packs enable, size, sub-region disables, permission, guard, memory attributes
package rpu_pkg;
	localparam int NREG = 8;
	localparam int AW = 32;
	// register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	localparam logic [7:0] MASK_OFS = 8'h08;
	localparam logic [7:0] FADDR_OFS = 8'h0c;
	localparam logic [7:0] RTAB_OFS = 8'h10;
	localparam logic [7:0] RATTR_OFS = 8'h04;
	localparam int RSTRIDE_LOG2 = 3;
	// control fields
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_DAP_LSB = 1;
	localparam int CTRL_DXN_BIT = 3;
	localparam int CTRL_DMEM_LSB = 4;
	localparam logic [31:0] CTRL_RST = 32'h0000_0006;
	// region attribute fields; region size is 2^(size+1) bytes
	localparam int AT_EN_BIT = 0;
	localparam int AT_SIZE_LSB = 1;
	localparam int AT_SRD_LSB = 8;
	localparam int AT_AP_LSB = 16;
	localparam int AT_XN_BIT = 18;
	localparam int AT_MEM_LSB = 20;
	localparam int MEM_W = 4;
	localparam int NSUB = 8;
	// status and mask bits
	localparam int ST_PERM_BIT = 0;
	localparam int ST_FETCH_BIT = 1;
	localparam int ST_W = 2;
	// sizes in bytes and the size codes derived from them
	localparam int GRANULE_BYTES = 32;
	localparam int SUBDIV_BYTES = 256;
	localparam logic [4:0] SIZE_MIN = 5'($clog2(GRANULE_BYTES) - 1);
	localparam logic [4:0] SIZE_SUB = 5'($clog2(SUBDIV_BYTES) - 1);
	localparam logic [4:0] SUB_SHIFT = 5'($clog2(NSUB) - 1);
	// permission codes
	localparam logic [1:0] AP_NONE = 2'h0;
	localparam logic [1:0] AP_RO = 2'h1;
	localparam logic [1:0] AP_RW = 2'h3;
	// region id of the background region, -1 in four bits
	localparam logic [3:0] DEF_REGION = 4'hf;
endpackage : rpu_pkg
